// ==== core_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module core_model
  import power_pkg::*;
(
  input  wire logic       ref_clk,
  input  wire logic [7:0] sfr_rdata,
  output logic      [7:0] sfr_addr,
  output logic            sfr_wr,
  output logic      [7:0] sfr_wdata,
  output logic            sfr_rd
);
  initial begin
    sfr_addr = 8'h00;
    sfr_wr = 1'b0;
    sfr_wdata = 8'h00;
    sfr_rd = 1'b0;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    sfr_addr <= a;
    sfr_wdata <= d;
    sfr_wr <= 1'b1;
    @(posedge ref_clk);
    sfr_wr <= 1'b0;
    sfr_wdata <= ~d;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    sfr_addr <= a;
    sfr_rd <= 1'b1;
    @(posedge ref_clk);
    sfr_rd <= 1'b0;
    #1;
    d = sfr_rdata;
  endtask : rd
  task automatic key_wr(input logic [7:0] d);
    wr(ADDR_WRITE_KEY, WRITE_KEY_VALUE);
    wr(ADDR_POWER_CONTROL, d & 8'hDF);
  endtask : key_wr
endmodule : core_model
`default_nettype wire

// ==== power_control_battery_switchover.sv ====
// Operation
// R1: The fourth scratch byte is freely read and written and keeps its value in every low-power mode.
// R2: Scratch bytes are cleared only when both main and battery supplies are lost.
// R3: The metering shutdown bit turns off modulators and metering processing.
// R4: The core shutdown bit stops the core and enters sleep while on battery.
// R5: A three-bit divider field, reset 010, sets core clock to 4.096 MHz over two to its power.
// R6: Power control bit 7 reads one, bit 3 reads zero, and software keeps bit 5 at zero.
// R7: A power control write is accepted only right after writing 0xA7 to the key register.
// R8: Switchover is enabled after reset and bit 1 of its configuration disables it.
// R9: Peripheral configuration bit 6 reads one on main supply and zero on battery.
// R10: With source select 01 a low supervisory input switches to battery.
// R11: With source select 00 a low main supply switches to battery.
// R12: With pin configuration X01 a falling edge on the control pin switches to battery.
// R13: Return to main supply needs every enabled condition to be healthy.
// R14: Metering converters are unavailable while on battery.
// R15: Switching supplies never resets or stalls the processor.
// R16: Each switch to battery and each return set latched flags cleared by writing zero.
// R17: Comparator outputs and the control pin pass a two-stage synchronizer.
`timescale 1ns/1ps
`default_nettype none

module power_control_battery_switchover
  import power_pkg::*;
#(
  parameter int DIV_W = 3
) (
  input  wire logic             ref_clk,
  input  wire logic             rstn,
  input  wire logic             supplies_lost,
  input  wire logic [7:0]       sfr_addr,
  input  wire logic             sfr_wr,
  input  wire logic [7:0]       sfr_wdata,
  input  wire logic             sfr_rd,
  output logic      [7:0]       sfr_rdata,
  input  wire logic             main_supply_low,
  input  wire logic             supervisory_input_low,
  input  wire logic             battery_control_pin,
  output logic                  supply_is_main,
  output logic                  metering_enable,
  output logic                  core_stop,
  output logic      [DIV_W-1:0] core_clock_divider
);

  // --------------------------------------------------------------
  // State
  // --------------------------------------------------------------
  typedef struct packed {
    logic [7:0]  power_control_reg;
    logic        key_armed;
    logic [7:0]  switchover_config_reg;
    logic [2:0]  interrupt_pin_config_reg;
    logic        switchover_flag;
    logic        restore_flag;
    supply_src_e src;
    logic        pin_prev;
    logic [7:0]  rdata;
    logic        rd_scratch;
  } ctl_s;

  ctl_s state_q;
  ctl_s state_d;

  logic [2:0] raw_in;
  logic [2:0] sync_in;
  logic       s_main_low;
  logic       s_sup_low;
  logic       s_pin;
  logic       scratch_hit;
  logic       scratch_wr;
  logic [1:0] scratch_idx;
  logic [7:0] scratch_rdata;

  // --------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------
  function automatic logic [1:0] scratch_index(input logic [7:0] addr);
    logic [7:0] diff;
    diff = addr - ADDR_SCRATCH_FIRST;
    return diff[1:0];
  endfunction : scratch_index

  function automatic logic [7:0] pc_view(input logic [7:0] v);
    logic [7:0] r;
    r = v;
    r[PC_FIXED_ONE_BIT]  = 1'b1;
    r[PC_FIXED_ZERO_BIT] = 1'b0;
    return r;
  endfunction : pc_view

  function automatic logic is_main(input supply_src_e s);
    return (s == SRC_MAIN);
  endfunction : is_main

  // --------------------------------------------------------------
  // Input synchronizer
  // --------------------------------------------------------------
  // Pin inverted so a cleared stage reads as idle high
  assign raw_in = {~battery_control_pin, supervisory_input_low, main_supply_low};

  // R17: two stages before decision
  sync_two_stage #(
    .WIDTH (3)
  ) u_sync (
    .ref_clk  (ref_clk),
    .rstn     (rstn),
    .async_in (raw_in),
    .sync_out (sync_in)
  );

  assign s_main_low = sync_in[0];
  assign s_sup_low  = sync_in[1];
  assign s_pin      = ~sync_in[2];

  // --------------------------------------------------------------
  // Scratch bytes
  // --------------------------------------------------------------
  assign scratch_hit = (sfr_addr >= ADDR_SCRATCH_FIRST) && (sfr_addr <= ADDR_SCRATCH_LAST);
  // R1: plain read/write store
  assign scratch_wr  = sfr_wr && scratch_hit;
  assign scratch_idx = scratch_index(sfr_addr);

  scratch_mem u_scratch (
    .ref_clk       (ref_clk),
    .supplies_lost (supplies_lost),
    .wr_en         (scratch_wr),
    .wr_idx        (scratch_idx),
    .wr_data       (sfr_wdata),
    .rd_idx        (scratch_idx),
    .rd_data       (scratch_rdata)
  );

  // --------------------------------------------------------------
  // Next state
  // --------------------------------------------------------------
  always_comb begin
    logic       auto_off;
    logic       sup_en;
    logic       pin_en;
    logic       main_trip;
    logic       sup_trip;
    logic       pin_trip;
    logic       main_ok;
    logic       sup_ok;
    logic       pin_ok;
    logic       key_match;
    logic       to_battery;
    logic       to_main;
    logic [1:0] sel;
    auto_off   = 1'b0;
    sup_en     = 1'b0;
    pin_en     = 1'b0;
    main_trip  = 1'b0;
    sup_trip   = 1'b0;
    pin_trip   = 1'b0;
    main_ok    = 1'b0;
    sup_ok     = 1'b0;
    pin_ok     = 1'b0;
    key_match  = 1'b0;
    to_battery = 1'b0;
    to_main    = 1'b0;
    sel        = 2'h0;
    state_d    = state_q;

    state_d.pin_prev   = s_pin;
    state_d.rd_scratch = sfr_rd && scratch_hit;

    // ------------------------------------------------------------
    // Supply source choice
    // ------------------------------------------------------------
    // R8: disable bit pins main supply
    auto_off = state_q.switchover_config_reg[SW_DISABLE_BIT];
    sel      = state_q.switchover_config_reg[SW_SELECT_MSB:0];
    // R10: supervisory check enable
    sup_en   = (sel == SEL_SUPERVISORY);
    // R12: control pin enable
    pin_en   = (state_q.interrupt_pin_config_reg[1:0] == PIN_CFG_BATTERY);

    // R11: low main supply
    main_trip  = ((sel == SEL_MAIN_MONITOR) || sup_en) && s_main_low;
    sup_trip   = sup_en && s_sup_low;
    // Edge seen on the synchronized pin
    pin_trip   = pin_en && state_q.pin_prev && !s_pin;
    to_battery = main_trip || sup_trip || pin_trip;
    // R13: all enabled conditions healthy
    main_ok    = !s_main_low;
    sup_ok     = !(sup_en && s_sup_low);
    pin_ok     = !(pin_en && !s_pin);
    to_main    = main_ok && sup_ok && pin_ok;

    // R15: supply choice never touches core
    unique case (state_q.src)
      SRC_MAIN: begin
        if (!auto_off && to_battery) begin
          state_d.src = SRC_BATTERY;
        end
      end
      SRC_BATTERY: begin
        if (auto_off || to_main) begin
          state_d.src = SRC_MAIN;
        end
      end
      default: begin
        state_d.src = SRC_MAIN;
      end
    endcase

    // ------------------------------------------------------------
    // Register writes
    // ------------------------------------------------------------
    key_match = (sfr_addr == ADDR_WRITE_KEY) && (sfr_wdata == WRITE_KEY_VALUE);
    if (sfr_wr) begin
      // R7: any write other than the key disarms
      state_d.key_armed = key_match;
      unique case (sfr_addr)
        ADDR_POWER_CONTROL: begin
          // R7: locked unless armed
          if (state_q.key_armed) begin
            state_d.power_control_reg = pc_view(sfr_wdata);
          end
        end
        ADDR_SWITCH_CONFIG: begin
          state_d.switchover_config_reg = sfr_wdata;
        end
        ADDR_INT_PIN_CONFIG: begin
          state_d.interrupt_pin_config_reg = sfr_wdata[2:0];
        end
        ADDR_SUPPLY_FLAGS: begin
          // R16: write zero clears
          if (!sfr_wdata[FLAG_SWITCHOVER_BIT]) begin
            state_d.switchover_flag = 1'b0;
          end
          if (!sfr_wdata[FLAG_RESTORE_BIT]) begin
            state_d.restore_flag = 1'b0;
          end
        end
        default: begin
        end
      endcase
    end

    // ------------------------------------------------------------
    // Flag events
    // ------------------------------------------------------------
    // R16: set wins over clear
    if (is_main(state_q.src) && !is_main(state_d.src)) begin
      state_d.switchover_flag = 1'b1;
    end
    if (!is_main(state_q.src) && is_main(state_d.src)) begin
      state_d.restore_flag = 1'b1;
    end

    // ------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------
    state_d.rdata = 8'h00;
    if (sfr_rd) begin
      unique case (sfr_addr)
        // R6: fixed reserved bits
        ADDR_POWER_CONTROL:  state_d.rdata = pc_view(state_q.power_control_reg);
        ADDR_SWITCH_CONFIG:  state_d.rdata = state_q.switchover_config_reg;
        ADDR_INT_PIN_CONFIG: state_d.rdata = {5'h0, state_q.interrupt_pin_config_reg};
        ADDR_SUPPLY_FLAGS: begin
          state_d.rdata[FLAG_SWITCHOVER_BIT] = state_q.switchover_flag;
          state_d.rdata[FLAG_RESTORE_BIT]    = state_q.restore_flag;
        end
        // R9: source status bit
        ADDR_PERIPHERAL_CONFIG_REG_CONFIG:  state_d.rdata[PERIPHERAL_CONFIG_REG_SOURCE_BIT] = is_main(state_q.src);
        default:             state_d.rdata = 8'h00;
      endcase
    end
  end

  // --------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      // R5: divider resets to 010
      state_q                          <= '0;
      state_q.power_control_reg        <= POWER_CONTROL_RESET;
      state_q.src                      <= SRC_MAIN;
      state_q.pin_prev                 <= 1'b1;
    end else begin
      state_q <= state_d;
    end
  end

  // --------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------
  assign sfr_rdata          = state_q.rd_scratch ? scratch_rdata : state_q.rdata;
  assign supply_is_main     = is_main(state_q.src);
  // R5: divider exponent out
  assign core_clock_divider = state_q.power_control_reg[PC_DIVIDER_MSB:0];
  // R3: metering off bit
  // R14: no metering on battery
  assign metering_enable    = supply_is_main && !state_q.power_control_reg[PC_METER_OFF_BIT];
  // R4: core stop only on battery
  assign core_stop          = !supply_is_main && state_q.power_control_reg[PC_CORE_OFF_BIT];

endmodule : power_control_battery_switchover

`default_nettype wire

// ==== power_control_battery_switchover_test.sv ====
`timescale 1ns/1ps
`default_nettype none
module power_control_battery_switchover_test
  import power_pkg::*;
;
  logic       ref_clk = 1'b0;
  logic       rstn = 1'b0;
  logic       supplies_lost = 1'b0;
  logic       main_low = 1'b0;
  logic       sup_low = 1'b0;
  logic       pin = 1'b1;
  wire  [7:0] addr, wdata, rdata;
  wire        wr, rd, src, meter, stop;
  wire  [2:0] div;
  int         failures = 0;
  int         n_tests = 0;
  always #10 ref_clk = ~ref_clk;
  core_model core (.ref_clk(ref_clk), .sfr_rdata(rdata), .sfr_addr(addr), .sfr_wr(wr),
    .sfr_wdata(wdata), .sfr_rd(rd));
  power_control_battery_switchover #(.DIV_W(3)) dut (.ref_clk(ref_clk), .rstn(rstn),
    .supplies_lost(supplies_lost), .sfr_addr(addr), .sfr_wr(wr), .sfr_wdata(wdata),
    .sfr_rd(rd), .sfr_rdata(rdata), .main_supply_low(main_low),
    .supervisory_input_low(sup_low), .battery_control_pin(pin), .supply_is_main(src),
    .metering_enable(meter), .core_stop(stop), .core_clock_divider(div));
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    n_tests++;
    if (g !== e) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic rchk(input string n, input logic [7:0] a, input logic [7:0] e);
    logic [7:0] v;
    core.rd(a, v);
    chk(n, e, v);
  endtask : rchk
  task automatic wt(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : wt
  task automatic src_is(input logic e);
    wt(5);
    @(negedge ref_clk);
    chk("source", {7'h0, e}, {7'h0, src});
  endtask : src_is
  task automatic conclude;
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : conclude
  initial begin
    #500000;
    failures++;
    conclude();
  end
  initial begin
    wt(6);
    rstn <= 1'b1;
    rchk("pctl", ADDR_POWER_CONTROL, POWER_CONTROL_RESET);
    rchk("peripheral_config_reg", ADDR_PERIPHERAL_CONFIG_REG_CONFIG, 8'h40);
    rchk("flags", ADDR_SUPPLY_FLAGS, 8'h00);
    rchk("unmapped", 8'h10, 8'h00);
    $display("test reset done");
    core.wr(ADDR_POWER_CONTROL, 8'h11);
    rchk("pctl", ADDR_POWER_CONTROL, 8'h82);
    core.wr(ADDR_WRITE_KEY, WRITE_KEY_VALUE);
    core.wr(ADDR_SCRATCH_LAST, 8'h00);
    core.wr(ADDR_POWER_CONTROL, 8'h11);
    rchk("pctl", ADDR_POWER_CONTROL, 8'h82);
    for (int i = 0; i < 8; i++) begin
      core.key_wr(8'h48 | 8'(i));
      @(negedge ref_clk);
      chk("div", 8'(i), {5'h0, div});
      chk("meter", 8'h00, {7'h0, meter});
      rchk("pctl", ADDR_POWER_CONTROL, 8'hC0 | 8'(i));
    end
    core.key_wr(8'h02);
    @(negedge ref_clk);
    chk("meter", 8'h01, {7'h0, meter});
    $display("test power control done");
    core.wr(ADDR_SCRATCH_LAST, 8'h5A);
    wt(1);
    rstn <= 1'b0;
    wt(3);
    rstn <= 1'b1;
    rchk("scratch", ADDR_SCRATCH_LAST, 8'h5A);
    supplies_lost <= 1'b1;
    wt(1);
    supplies_lost <= 1'b0;
    rchk("scratch", ADDR_SCRATCH_LAST, 8'h00);
    $display("test scratch done");
    wt(1);
    sup_low <= 1'b1;
    src_is(1'b1);
    core.wr(ADDR_SWITCH_CONFIG, {6'h0, SEL_SUPERVISORY});
    src_is(1'b0);
    wt(1);
    sup_low <= 1'b0;
    src_is(1'b1);
    rchk("flags", ADDR_SUPPLY_FLAGS, 8'h82);
    core.wr(ADDR_SUPPLY_FLAGS, 8'h00);
    rchk("flags", ADDR_SUPPLY_FLAGS, 8'h00);
    core.wr(ADDR_SWITCH_CONFIG, 8'h00);
    main_low <= 1'b1;
    src_is(1'b0);
    chk("meter", 8'h00, {7'h0, meter});
    rchk("peripheral_config_reg", ADDR_PERIPHERAL_CONFIG_REG_CONFIG, 8'h00);
    core.key_wr(8'h12);
    @(negedge ref_clk);
    chk("stop", 8'h01, {7'h0, stop});
    wt(1);
    main_low <= 1'b0;
    src_is(1'b1);
    chk("stop", 8'h00, {7'h0, stop});
    rchk("pctl", ADDR_POWER_CONTROL, 8'h92);
    core.key_wr(8'h02);
    $display("test monitors done");
    core.wr(ADDR_SWITCH_CONFIG, 8'h02);
    main_low <= 1'b1;
    src_is(1'b1);
    core.wr(ADDR_SWITCH_CONFIG, 8'h00);
    src_is(1'b0);
    wt(1);
    main_low <= 1'b0;
    src_is(1'b1);
    core.wr(ADDR_INT_PIN_CONFIG, {5'h0, 1'b1, PIN_CFG_BATTERY});
    pin <= 1'b0;
    src_is(1'b0);
    wt(1);
    pin <= 1'b1;
    src_is(1'b1);
    $display("test switchover done");
    conclude();
  end
endmodule : power_control_battery_switchover_test
`default_nettype wire

// ==== power_monitor.sv ====
`timescale 1ns/1ps
`default_nettype none
module power_monitor
  import power_pkg::*;
#(
  parameter int DIV_W = 3
) (
  input wire logic             ref_clk,
  input wire logic             rstn,
  input wire logic             supplies_lost,
  input wire logic [7:0]       sfr_addr,
  input wire logic             sfr_wr,
  input wire logic [7:0]       sfr_wdata,
  input wire logic             sfr_rd,
  input wire logic [7:0]       sfr_rdata,
  input wire logic             main_supply_low,
  input wire logic             supervisory_input_low,
  input wire logic             battery_control_pin,
  input wire logic             supply_is_main,
  input wire logic             metering_enable,
  input wire logic             core_stop,
  input wire logic [DIV_W-1:0] core_clock_divider
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  // ----------------
  // Assertions
  // ----------------
  // battery blocks metering
  meter_on_main_a: assert property (metering_enable |-> supply_is_main)
    else $error("metering enabled on battery");
  stop_on_bat_a: assert property (core_stop |-> !supply_is_main)
    else $error("core stopped on main supply");
  quiet_src_a: assert property (($stable(main_supply_low) && $stable(supervisory_input_low)
    && $stable(battery_control_pin) && !sfr_wr) [*5] |-> $stable(supply_is_main))
    else $error("source moved without cause");
  div_by_write_a: assert property (!$stable(core_clock_divider)
    |-> $past(sfr_wr && sfr_addr == ADDR_POWER_CONTROL)) else $error("divider moved alone");
  meter_cause_a: assert property (!$stable(metering_enable) |-> !$stable(supply_is_main)
    || $past(sfr_wr && sfr_addr == ADDR_POWER_CONTROL)) else $error("metering moved alone");
  fall_cause_a: assert property ($fell(supply_is_main) |-> $past(main_supply_low, 3)
    || $past(supervisory_input_low, 3) || !$past(battery_control_pin, 3))
    else $error("switch to battery without cause");
  rise_cause_a: assert property ($rose(supply_is_main) |-> !$past(main_supply_low, 3)
    || $past(sfr_wr, 1) || $past(sfr_wr, 2) || $past(sfr_wr, 3))
    else $error("return with main low");
  rdata_idle_a: assert property (!$past(sfr_rd) |-> sfr_rdata == 8'h00)
    else $error("read data without read");
  cover property ($fell(supply_is_main));
  cover property ($rose(supply_is_main));
  cover property (core_stop);
endmodule : power_monitor
bind power_control_battery_switchover power_monitor #(.DIV_W(DIV_W)) mon (
  .ref_clk(ref_clk), .rstn(rstn), .supplies_lost(supplies_lost), .sfr_addr(sfr_addr),
  .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata),
  .main_supply_low(main_supply_low), .supervisory_input_low(supervisory_input_low),
  .battery_control_pin(battery_control_pin), .supply_is_main(supply_is_main),
  .metering_enable(metering_enable), .core_stop(core_stop),
  .core_clock_divider(core_clock_divider)
);
`default_nettype wire

// ==== power_pkg.sv ====
package power_pkg;

  // --------------------------------------------------------------
  // Register addresses
  // --------------------------------------------------------------
  localparam logic [7:0] ADDR_WRITE_KEY      = 8'hC1;
  localparam logic [7:0] ADDR_POWER_CONTROL  = 8'hC5;
  localparam logic [7:0] ADDR_SUPPLY_FLAGS   = 8'hF8;
  localparam logic [7:0] ADDR_PERIPHERAL_CONFIG_REG_CONFIG  = 8'hF4;
  localparam logic [7:0] ADDR_SWITCH_CONFIG  = 8'hF5;
  localparam logic [7:0] ADDR_INT_PIN_CONFIG = 8'hFF;
  localparam logic [7:0] ADDR_SCRATCH_FIRST  = 8'hFB;
  localparam logic [7:0] ADDR_SCRATCH_LAST   = 8'hFE;

  // --------------------------------------------------------------
  // Field layout and reset values
  // --------------------------------------------------------------
  localparam logic [7:0] WRITE_KEY_VALUE     = 8'hA7;
  localparam logic [7:0] POWER_CONTROL_RESET = 8'h82;
  localparam int         PC_FIXED_ONE_BIT    = 7;
  localparam int         PC_METER_OFF_BIT    = 6;
  localparam int         PC_RESERVED5_BIT    = 5;
  localparam int         PC_CORE_OFF_BIT     = 4;
  localparam int         PC_FIXED_ZERO_BIT   = 3;
  localparam int         PC_DIVIDER_MSB      = 2;
  localparam int         SW_DISABLE_BIT      = 1;
  localparam int         SW_SELECT_MSB       = 1;
  localparam logic [1:0] SEL_MAIN_MONITOR    = 2'h0;
  localparam logic [1:0] SEL_SUPERVISORY     = 2'h1;
  localparam logic [1:0] PIN_CFG_BATTERY     = 2'h1;
  localparam int         PERIPHERAL_CONFIG_REG_SOURCE_BIT   = 6;
  localparam int         FLAG_RESTORE_BIT    = 7;
  localparam int         FLAG_SWITCHOVER_BIT = 1;
  localparam int         SCRATCH_WORDS       = 4;
  localparam int         SCRATCH_INDEX_W     = 2;

  typedef enum logic [1:0] {
    SRC_MAIN    = 2'b01,
    SRC_BATTERY = 2'b10
  } supply_src_e;

endpackage : power_pkg

// ==== scratch_mem.sv ====
`timescale 1ns/1ps
`default_nettype none

module scratch_mem
  import power_pkg::*;
#(
  parameter int WORDS = SCRATCH_WORDS,
  parameter int IDX_W = SCRATCH_INDEX_W
) (
  input  wire logic             ref_clk,
  input  wire logic             supplies_lost,
  input  wire logic             wr_en,
  input  wire logic [IDX_W-1:0] wr_idx,
  input  wire logic [7:0]       wr_data,
  input  wire logic [IDX_W-1:0] rd_idx,
  output logic      [7:0]       rd_data
);

  typedef struct packed {
    logic [WORDS-1:0][7:0] words;
    logic [7:0]            rdata;
  } mem_s;

  mem_s state_q;
  mem_s state_d;

  always_comb begin
    state_d       = state_q;
    state_d.rdata = state_q.words[rd_idx];
    if (wr_en) begin
      state_d.words[wr_idx] = wr_data;
    end
  end

  // R2: only total supply loss clears
  always_ff @(posedge ref_clk) begin
    if (supplies_lost) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  assign rd_data = state_q.rdata;

endmodule : scratch_mem

`default_nettype wire

// ==== sync_two_stage.sv ====
`timescale 1ns/1ps
`default_nettype none

module sync_two_stage #(
  parameter int WIDTH = 3
) (
  input  wire logic             ref_clk,
  input  wire logic             rstn,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  typedef struct packed {
    logic [WIDTH-1:0] first;
    logic [WIDTH-1:0] second;
  } sync_s;

  sync_s state_q;
  sync_s state_d;

  always_comb begin
    state_d.first  = async_in;
    state_d.second = state_q.first;
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  assign sync_out = state_q.second;

endmodule : sync_two_stage

`default_nettype wire
